// ===== hm12_defines.svh
`ifndef HM12_DEFINES_SVH
`define HM12_DEFINES_SVH

// ------------------------------------------------------------
// command encodings and synchroniser reset value
// ------------------------------------------------------------
`define HM12_DIR_FWD 1'h0
`define HM12_DIR_REV 1'h1
`define HM12_SPD_LOW 1'h0
`define HM12_SPD_HIGH 1'h1
`define HM12_SYNC_RESET 3'h0

// ------------------------------------------------------------
// flag levels
// ------------------------------------------------------------
`define HM12_FLAG_OFF 1'h0
`define HM12_FLAG_ON 1'h1
`endif

// ===== hm12_pkg.sv
package hm12_pkg;
    // sequencer states
    typedef enum logic [3:0] {
        HM12_IDLE = 4'h0,
        HM12_A_FWD_LO = 4'h1,
        HM12_A_REV_LO = 4'h2,
        HM12_A_WAIT_Z = 4'h3,
        HM12_B_REV_HI = 4'h4,
        HM12_B_FWD_HI = 4'h5,
        HM12_B_FWD_LO = 4'h6,
        HM12_B_REV_LO = 4'h7,
        HM12_B_WAIT_Z = 4'h8,
        HM12_DONE = 4'h9
    } hm12_state_t;
endpackage

// ===== hm12_sync_edge.sv
`timescale 1ns/10ps
`include "hm12_defines.svh"
// ------------------------------------------------------------
// three-stage synchroniser with edge detection
// ------------------------------------------------------------
module hm12_sync_edge (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // asynchronous pin
    input wire logic i_pin,
    // filtered level and edges
    output logic o_level,
    output logic o_rise,
    output logic o_fall
);
    logic [2:0] sync_r;
    logic [2:0] sync_nxt;
    logic level_r;
    logic level_nxt;

    // shift chain; stage 0 is read only by stage 1
    always_comb begin
        sync_nxt = {sync_r[1:0], i_pin};
        level_nxt = level_r;
        if (sync_r[1] == sync_r[2]) begin
            level_nxt = sync_r[2];
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            sync_r <= `HM12_SYNC_RESET;
            level_r <= `HM12_FLAG_OFF;
        end else begin
            sync_r <= sync_nxt;
            level_r <= level_nxt;
        end
    end

    // one-cycle edge pulses from registered samples
    assign o_level = level_r;
    assign o_rise = level_nxt & ~level_r;
    assign o_fall = ~level_nxt & level_r;
endmodule // hm12_sync_edge

// ===== hm12_sequencer.sv
`timescale 1ns/10ps
`include "hm12_defines.svh"
// ------------------------------------------------------------
// homing sequencer, one method, two cases
// ------------------------------------------------------------
module hm12_sequencer (
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_reset,
    // control
    input wire logic i_start,
    input wire logic i_abort,
    // sensors, asynchronous
    input wire logic i_origin_sw,
    input wire logic i_rev_limit,
    input wire logic i_index,
    // motion command
    output logic o_run,
    output logic o_dir_rev,
    output logic o_speed_high,
    // status
    output logic o_busy,
    output logic o_done,
    output logic o_unsupported,
    output hm12_pkg::hm12_state_t o_state
);
    import hm12_pkg::*;

    logic org_lvl;
    logic org_rise;
    logic org_fall;
    logic lim_lvl;
    logic lim_rise;
    logic idx_rise;
    hm12_state_t state_r;
    hm12_state_t state_nxt;
    logic run_r;
    logic run_nxt;
    logic dir_r;
    logic dir_nxt;
    logic spd_r;
    logic spd_nxt;
    logic done_r;
    logic done_nxt;
    logic unsup_r;
    logic unsup_nxt;
    logic busy_r;
    logic busy_nxt;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    hm12_sync_edge u_sync_org (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_pin(i_origin_sw),
        .o_level(org_lvl),
        .o_rise(org_rise),
        .o_fall(org_fall)
    );

    hm12_sync_edge u_sync_lim (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_pin(i_rev_limit),
        .o_level(lim_lvl),
        .o_rise(lim_rise),
        .o_fall()
    );

    hm12_sync_edge u_sync_idx (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_pin(i_index),
        .o_level(),
        .o_rise(idx_rise),
        .o_fall()
    );

    // ------------------------------------------------------------
    // sequencer next state
    // ------------------------------------------------------------
    // one step per edge, or on the limit level in case b; edges arrive as one-cycle pulses, so each acts once
    always_comb begin
        state_nxt = state_r;
        run_nxt = run_r;
        dir_nxt = dir_r;
        spd_nxt = spd_r;
        case (state_r)
            HM12_IDLE, HM12_DONE: begin
                // start picks the case from the filtered origin level
                if (i_start) begin
                    run_nxt = `HM12_FLAG_ON;
                    if (org_lvl) begin
                        state_nxt = HM12_A_FWD_LO;
                        dir_nxt = `HM12_DIR_FWD;
                        spd_nxt = `HM12_SPD_LOW;
                    end else begin
                        state_nxt = HM12_B_REV_HI;
                        dir_nxt = `HM12_DIR_REV;
                        spd_nxt = `HM12_SPD_HIGH;
                    end
                end
            end
            // case a: leave the switch forward, creep back onto it in reverse
            HM12_A_FWD_LO: begin
                if (org_fall) begin
                    state_nxt = HM12_A_REV_LO;
                    dir_nxt = `HM12_DIR_REV;
                    spd_nxt = `HM12_SPD_LOW;
                end
            end
            HM12_A_REV_LO: begin
                if (org_rise) begin
                    state_nxt = HM12_A_WAIT_Z; // arm index search
                end
            end
            // case b: reverse at speed until the limit turns the axis round
            HM12_B_REV_HI: begin
                if (org_rise || org_fall) begin
                    // origin reached first: outside this block's cases
                    state_nxt = HM12_DONE;
                    run_nxt = `HM12_FLAG_OFF;
                end else if (lim_rise || lim_lvl) begin
                    // level too: an axis already on the limit turns at once
                    state_nxt = HM12_B_FWD_HI;
                    dir_nxt = `HM12_DIR_FWD;
                    spd_nxt = `HM12_SPD_HIGH;
                end
            end
            HM12_B_FWD_HI: begin
                if (org_rise) begin
                    state_nxt = HM12_B_FWD_LO;
                    dir_nxt = `HM12_DIR_FWD;
                    spd_nxt = `HM12_SPD_LOW;
                end
            end
            HM12_B_FWD_LO: begin
                if (org_fall) begin
                    state_nxt = HM12_B_REV_LO;
                    dir_nxt = `HM12_DIR_REV;
                    spd_nxt = `HM12_SPD_LOW;
                end
            end
            HM12_B_REV_LO: begin
                if (org_rise) begin
                    state_nxt = HM12_B_WAIT_Z; // arm index search
                end
            end
            // an index that coincides with the arming rise is not counted
            HM12_A_WAIT_Z, HM12_B_WAIT_Z: begin
                if (idx_rise) begin
                    state_nxt = HM12_DONE;
                    run_nxt = `HM12_FLAG_OFF; // stop on index
                end
            end
            default: begin
                state_nxt = HM12_IDLE;
                run_nxt = `HM12_FLAG_OFF;
            end
        endcase
        // abort stops motion from any active state
        if (i_abort && state_r != HM12_IDLE && state_r != HM12_DONE) begin
            state_nxt = HM12_IDLE;
            run_nxt = `HM12_FLAG_OFF;
        end
    end

    // ------------------------------------------------------------
    // sequencer registers
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            state_r <= HM12_IDLE;
            run_r <= `HM12_FLAG_OFF;
            dir_r <= `HM12_DIR_FWD;
            spd_r <= `HM12_SPD_LOW;
        end else begin
            state_r <= state_nxt;
            run_r <= run_nxt;
            dir_r <= dir_nxt;
            spd_r <= spd_nxt;
        end
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    // cleared on start, set by the way the run ended
    always_comb begin
        done_nxt = done_r;
        unsup_nxt = unsup_r;
        if ((state_r == HM12_IDLE || state_r == HM12_DONE) && i_start) begin
            done_nxt = `HM12_FLAG_OFF;
            unsup_nxt = `HM12_FLAG_OFF;
        end
        if (state_nxt == HM12_DONE) begin
            if (state_r == HM12_A_WAIT_Z || state_r == HM12_B_WAIT_Z) begin
                done_nxt = `HM12_FLAG_ON; // homed on index
            end
            if (state_r == HM12_B_REV_HI) begin
                unsup_nxt = `HM12_FLAG_ON; // origin edge before any limit
            end
        end
        // busy follows the state about to be entered, so it lines up with it
        busy_nxt = (state_nxt != HM12_IDLE) && (state_nxt != HM12_DONE);
    end

    // status registers
    always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            done_r <= `HM12_FLAG_OFF;
            unsup_r <= `HM12_FLAG_OFF;
            busy_r <= `HM12_FLAG_OFF;
        end else begin
            done_r <= done_nxt;
            unsup_r <= unsup_nxt;
            busy_r <= busy_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign o_run = run_r;
    assign o_dir_rev = dir_r;
    assign o_speed_high = spd_r;
    assign o_busy = busy_r;
    assign o_done = done_r;
    assign o_unsupported = unsup_r;
    assign o_state = state_r;
endmodule // hm12_sequencer

// ===== hm12_motor_model.sv
`timescale 1ns/10ps
// ----
// switches and encoder index
// ----
module hm12_motor_model (
    // clock
    input wire logic i_ref_clk,
    // sensor pins
    output logic o_origin_sw,
    output logic o_rev_limit,
    output logic o_index
);
    // pins idle low
    initial begin
        o_origin_sw = 1'h0;
        o_rev_limit = 1'h0;
        o_index = 1'h0;
    end
    // switch move, held past the filter
    task automatic set_sw(input logic org, input logic lim);
        @(negedge i_ref_clk);
        o_origin_sw = org;
        o_rev_limit = lim;
        repeat (6) @(negedge i_ref_clk);
    endtask
    // one index pulse, three cycles wide
    task automatic pulse_index();
        @(negedge i_ref_clk);
        o_index = 1'h1;
        repeat (3) @(negedge i_ref_clk);
        o_index = 1'h0;
        repeat (3) @(negedge i_ref_clk);
    endtask
endmodule // hm12_motor_model

// ===== hm12_sequencer_asserts.sv
`timescale 1ns/10ps
// ----
// sequencer checks
// ----
module hm12_sequencer_asserts import hm12_pkg::*; (
    // all ports of the sequencer
    input wire logic i_ref_clk, i_reset, i_start, i_abort,
    input wire logic i_origin_sw, i_rev_limit, i_index,
    input wire logic o_run, o_dir_rev, o_speed_high, o_busy, o_done, o_unsupported,
    input wire hm12_pkg::hm12_state_t o_state
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    AST_A_FWD: assert property (o_state == HM12_A_FWD_LO |-> o_run && !o_dir_rev && !o_speed_high)
        else $error("forward low command wrong");
    AST_A_FALL: assert property (o_state == HM12_A_FWD_LO && $fell(i_origin_sw) && !i_abort
        |=> o_state == HM12_A_FWD_LO [*2] ##[1:3] (o_state == HM12_A_REV_LO && o_dir_rev))
        else $error("origin fall not followed");
    AST_A_STOP: assert property (o_state == HM12_A_WAIT_Z && $rose(i_index) && !i_abort
        |-> ##[3:5] (o_state == HM12_DONE && o_done && !o_run))
        else $error("no stop on index");
    AST_B_REV: assert property (o_state == HM12_B_REV_HI |-> o_run && o_dir_rev && o_speed_high)
        else $error("reverse high command wrong");
    AST_B_LIM: assert property (o_state == HM12_B_REV_HI && $rose(i_rev_limit) && !i_abort
        |-> ##[3:5] (o_state == HM12_B_FWD_HI && !o_dir_rev && o_speed_high))
        else $error("no reversal on limit");
    AST_B_FWD_LO: assert property (o_state == HM12_B_FWD_LO |-> o_run && !o_dir_rev && !o_speed_high)
        else $error("forward low command wrong");
    AST_B_REV_LO: assert property (o_state == HM12_B_REV_LO |-> o_run && o_dir_rev && !o_speed_high)
        else $error("reverse low command wrong");
    AST_B_STOP: assert property (o_state == HM12_B_WAIT_Z && $rose(i_index) && !i_abort
        |-> ##[3:5] (o_state == HM12_DONE && o_done && !o_run))
        else $error("no stop on index");
endmodule // hm12_sequencer_asserts

bind hm12_sequencer hm12_sequencer_asserts chk_u (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
    .i_start(i_start), .i_abort(i_abort), .i_origin_sw(i_origin_sw), .i_rev_limit(i_rev_limit),
    .i_index(i_index), .o_run(o_run), .o_dir_rev(o_dir_rev), .o_speed_high(o_speed_high),
    .o_busy(o_busy), .o_done(o_done), .o_unsupported(o_unsupported), .o_state(o_state));

// ===== hm12_tb.sv
`timescale 1ns/10ps
// ----
// sequencer bench
// ----
module tb;
    import hm12_pkg::*;
    logic i_ref_clk = 1'h0;
    logic i_reset = 1'h1;
    logic i_start = 1'h0;
    logic i_abort = 1'h0;
    logic org, lim, idx, run, dir, spd, busy, done, unsup;
    hm12_state_t st;
    int fails = 0;
    int num_checks = 0;
    // 200 MHz clock
    always #2.5 i_ref_clk = ~i_ref_clk;
    hm12_motor_model mot_u (.i_ref_clk(i_ref_clk), .o_origin_sw(org), .o_rev_limit(lim),
        .o_index(idx));
    hm12_sequencer dut_u (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_start(i_start),
        .i_abort(i_abort), .i_origin_sw(org), .i_rev_limit(lim), .i_index(idx), .o_run(run),
        .o_dir_rev(dir), .o_speed_high(spd), .o_busy(busy), .o_done(done),
        .o_unsupported(unsup), .o_state(st));
    task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // bounded wait for a state, then run, dir, speed
    task automatic step(input hm12_state_t s, input logic [2:0] cmd);
        for (int i = 0; i < 12 && st !== s; i++) @(negedge i_ref_clk);
        check("state", st, s);
        check("command", {1'h0, run, dir, spd}, {1'h0, cmd});
    endtask
    task automatic kick();
        @(negedge i_ref_clk);
        i_start = 1'h1;
        @(negedge i_ref_clk);
        i_start = 1'h0;
    endtask
    task automatic home_on_switch();
        mot_u.set_sw(1'h1, 1'h0);
        kick();
        step(HM12_A_FWD_LO, 3'h4);
        check("busy", {3'h0, busy}, 4'h1);
        mot_u.set_sw(1'h0, 1'h0);
        step(HM12_A_REV_LO, 3'h6);
        mot_u.pulse_index();
        step(HM12_A_REV_LO, 3'h6);
        mot_u.set_sw(1'h1, 1'h0);
        step(HM12_A_WAIT_Z, 3'h6);
        mot_u.pulse_index();
        step(HM12_DONE, 3'h2);
        check("done", {3'h0, done}, 4'h1);
        check("busy", {3'h0, busy}, 4'h0);
    endtask
    task automatic home_via_limit();
        mot_u.set_sw(1'h0, 1'h0);
        kick();
        step(HM12_B_REV_HI, 3'h7);
        check("done", {3'h0, done}, 4'h0);
        mot_u.set_sw(1'h0, 1'h1);
        step(HM12_B_FWD_HI, 3'h5);
        mot_u.set_sw(1'h1, 1'h0);
        step(HM12_B_FWD_LO, 3'h4);
        mot_u.set_sw(1'h0, 1'h0);
        step(HM12_B_REV_LO, 3'h6);
        mot_u.set_sw(1'h1, 1'h0);
        step(HM12_B_WAIT_Z, 3'h6);
        mot_u.pulse_index();
        step(HM12_DONE, 3'h2);
        check("done", {3'h0, done}, 4'h1);
    endtask
    // limit already made at start: turns at once, then abort mid-run
    task automatic limit_at_start();
        mot_u.set_sw(1'h0, 1'h1);
        kick();
        step(HM12_B_FWD_HI, 3'h5);
        mot_u.set_sw(1'h1, 1'h0);
        step(HM12_B_FWD_LO, 3'h4);
        i_abort = 1'h1;
        @(negedge i_ref_clk);
        i_abort = 1'h0;
        step(HM12_IDLE, 3'h0);
        check("busy", {3'h0, busy}, 4'h0);
    endtask
    // origin edge before any limit: not handled here, flagged and stopped
    task automatic origin_first();
        mot_u.set_sw(1'h0, 1'h0);
        kick();
        step(HM12_B_REV_HI, 3'h7);
        mot_u.set_sw(1'h1, 1'h0);
        step(HM12_DONE, 3'h3);
        check("unsupported", {3'h0, unsup}, 4'h1);
        check("done", {3'h0, done}, 4'h0);
    endtask
    task automatic abort_run();
        mot_u.set_sw(1'h0, 1'h0);
        kick();
        step(HM12_B_REV_HI, 3'h7);
        check("unsupported", {3'h0, unsup}, 4'h0);
        i_abort = 1'h1;
        @(negedge i_ref_clk);
        i_abort = 1'h0;
        step(HM12_IDLE, 3'h3);
        check("busy", {3'h0, busy}, 4'h0);
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (3) @(negedge i_ref_clk);
        i_reset = 1'h0;
        home_on_switch();
        home_via_limit();
        limit_at_start();
        origin_first();
        abort_run();
        complete_run();
    end
    // watchdog
    initial begin
        #20000;
        fails++;
        complete_run();
    end
endmodule // tb
